// >>> hdl/csr_clock_reset.sv
// Clock source selection, guard filter and reset sequencer
`timescale 1ns/1ps
module csr_clock_reset #(
    parameter int STAB_LEN = csr_pkg::STAB_CYCLES,
    parameter bit GUARD_EN = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic main_osc_edge_i,
    input wire logic backup_osc_edge_i,
    input wire logic reset_pin_n_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    input wire logic power_on_i,
    input wire logic watchdog_end_i,
    input wire logic low_supply_i,
    input wire logic stop_mode_i,
    input wire logic return_from_interrupt_i,
    input wire logic irq_pending_i,
    output logic main_osc_enable_o,
    output logic backup_osc_enable_o,
    output logic clk_tick_o,
    output logic on_backup_o,
    output logic periph_tick_o,
    output logic cpu_tick_o,
    output logic core_reset_o,
    output logic io_pullup_o,
    output logic watchdog_reinit_o,
    output logic stack_clear_o,
    output logic pc_load_o,
    output logic [11:0] pc_vector_o,
    output logic nmi_context_o,
    output logic serve_irq_o
);
    import csr_pkg::*;

    logic [7:0] ctrl;
    logic main_running;
    logic [3:0] miss_cnt;
    logic [4:0] start_cnt;
    logic [1:0] gap_cnt;
    logic raw_tick;
    logic [3:0] pdiv;
    logic [3:0] cdiv;
    logic [2:0] stretch;
    logic pin_sync1;
    logic pin_sync2;
    logic src_sync1;
    logic src_sync2;
    logic any_reset;
    logic internal_src;
    logic [15:0] stab_cnt;
    logic restart_req;
    csr_state_type state;
    csr_state_type next_state;
    logic bus_req;
    logic hit;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit = (wb_adr_i == CTRL_ADDR) || (wb_adr_i == STAT_ADDR);

    // Single-cycle answer, dropped the following cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end
        else
        begin
            wb_ack_o <= bus_req && hit;
            wb_err_o <= bus_req && !hit;
            if (bus_req && wb_adr_i == CTRL_ADDR)
                wb_dat_o <= ctrl;
            else if (bus_req && wb_adr_i == STAT_ADDR)
                wb_dat_o <= {4'h0, state == ST_RUN, core_reset_o, on_backup_o, main_running};
            else
                wb_dat_o <= 8'h00;
        end
    end

    // Only bit 2 acts; the rest just hold software's value
    always_ff @(posedge clk_i)
    begin
        if (rst_i || core_reset_o)
            ctrl <= CTRL_RESET; // R22
        else if (bus_req && wb_we_i && wb_sel_i && wb_adr_i == CTRL_ADDR)
            ctrl <= wb_dat_i; // R07
    end

    // Stop bit only honoured with the guard, else there is no fallback clock
    assign main_osc_enable_o = !(GUARD_EN && ctrl[OSC_OFF_BIT]); // R06

    assign restart_req = !main_osc_enable_o || core_reset_o;

    // Missing-edge watchdog on the main oscillator plus start-up delay
    always_ff @(posedge clk_i)
    begin
        if (rst_i || restart_req)
        begin
            miss_cnt <= 4'h0;
            start_cnt <= 5'h00;
            main_running <= 1'b0;
        end
        else if (main_osc_edge_i)
        begin
            miss_cnt <= 4'h0;
            if (start_cnt == 5'(STARTUP_CYCLES))
                main_running <= 1'b1; // R22
            else
                start_cnt <= start_cnt + 5'h01;
        end
        else if (miss_cnt != 4'(MISS_LIMIT))
            miss_cnt <= miss_cnt + 4'h1;
        else
        begin
            main_running <= 1'b0; // R01
            start_cnt <= 5'h00;
        end
    end

    assign on_backup_o = GUARD_EN && !main_running; // R02
    assign backup_osc_enable_o = on_backup_o; // R05

    // Guard enforces a least gap between internal ticks
    always_comb
    begin
        if (on_backup_o)
            raw_tick = backup_osc_edge_i; // R03 R04
        else
            raw_tick = main_osc_edge_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            gap_cnt <= 2'h0;
        else if (clk_tick_o)
            gap_cnt <= 2'(GUARD_MIN_GAP);
        else if (gap_cnt != 2'h0)
            gap_cnt <= gap_cnt - 2'h1;
    end

    assign clk_tick_o = raw_tick && (!GUARD_EN || gap_cnt == 2'h0); // R08

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pdiv <= 4'h0;
            cdiv <= 4'h0;
        end
        else if (clk_tick_o)
        begin
            pdiv <= (pdiv == PERIPH_DIV - 4'h1) ? 4'h0 : pdiv + 4'h1; // R21
            cdiv <= (cdiv == CPU_DIV - 4'h1) ? 4'h0 : cdiv + 4'h1; // R21
        end
    end

    assign periph_tick_o = clk_tick_o && pdiv == PERIPH_DIV - 4'h1;
    assign cpu_tick_o = clk_tick_o && cdiv == CPU_DIV - 4'h1;

    // Tick counts kept apart from the dividers, only for their checks
    logic [3:0] periph_seen;
    logic [3:0] cpu_seen;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            periph_seen <= 4'h0;
            cpu_seen <= 4'h0;
        end
        else if (clk_tick_o)
        begin
            periph_seen <= periph_tick_o ? 4'h0 : periph_seen + 4'h1;
            cpu_seen <= cpu_tick_o ? 4'h0 : cpu_seen + 4'h1;
        end
    end

    // Pin and detector requests synchronised before use
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
            src_sync1 <= 1'b1;
            src_sync2 <= 1'b1;
        end
        else
        begin
            pin_sync1 <= !reset_pin_n_i; // R24
            pin_sync2 <= pin_sync1;
            src_sync1 <= power_on_i || watchdog_end_i || low_supply_i; // R09 R14 R16
            src_sync2 <= src_sync1;
        end
    end

    // Stretch short pin pulses so they are never missed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            stretch <= 3'h0;
        else if (pin_sync2)
            stretch <= 3'(PIN_STRETCH); // R10
        else if (stretch != 3'h0)
            stretch <= stretch - 3'h1;
    end

    assign internal_src = src_sync2;
    assign any_reset = internal_src || pin_sync2 || stretch != 3'h0; // R09

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RESET:
                if (!any_reset)
                    next_state = ST_STAB; // R11 R12
            ST_STAB:
                if (stab_cnt == 16'(STAB_LEN - 1) && clk_tick_o)
                    next_state = ST_INIT; // R13 R15
            ST_INIT:
                next_state = ST_RUN;
            ST_RUN:
                next_state = ST_RUN;
            default:
                next_state = ST_RESET;
        endcase
        if (any_reset)
            next_state = ST_RESET;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // Counted on the active clock so a slow oscillator stretches it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state != ST_STAB)
            stab_cnt <= 16'h0000;
        else if (clk_tick_o)
            stab_cnt <= stab_cnt + 16'h0001; // R23
    end

    assign core_reset_o = state == ST_RESET || state == ST_STAB;
    assign io_pullup_o = core_reset_o; // R11 R12 R13
    assign watchdog_reinit_o = core_reset_o; // R14
    assign reset_pin_o = 1'b0;
    // Wired-AND: only ever pulls low
    assign reset_pin_oe_o = internal_src && core_reset_o; // R17
    assign stack_clear_o = state == ST_INIT; // R18
    assign pc_load_o = state == ST_INIT; // R18
    assign pc_vector_o = RESET_VECTOR;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || core_reset_o)
            nmi_context_o <= 1'b1; // R19
        else if (return_from_interrupt_i)
            nmi_context_o <= 1'b0;
    end

    assign serve_irq_o = nmi_context_o && return_from_interrupt_i && irq_pending_i; // R20

    // Clock source, guard and divider checks
    a_backup_after_miss: assert property (@(posedge clk_i) disable iff (rst_i) // R01
        (GUARD_EN && miss_cnt == 4'(MISS_LIMIT) && !main_osc_edge_i && !restart_req)
        |=> on_backup_o) else $error("backup not started");
    a_no_backup_unguarded: assert property (@(posedge clk_i) disable iff (rst_i) // R02
        !GUARD_EN |-> !backup_osc_enable_o) else $error("backup without guard");
    a_stop_bit: assert property (@(posedge clk_i) disable iff (rst_i) // R06
        (GUARD_EN && ctrl[OSC_OFF_BIT]) |-> !main_osc_enable_o) else $error("stop ignored");
    a_stop_main: assert property (@(posedge clk_i) disable iff (rst_i) // R06
        (GUARD_EN && ctrl[OSC_OFF_BIT]) |=> !main_running)
        else $error("main clock not stopped");
    a_osc_restart: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        core_reset_o |=> main_osc_enable_o)
        else $error("main clock not restarted");
    a_backup_stops: assert property (@(posedge clk_i) disable iff (rst_i) // R05
        (!restart_req && main_osc_edge_i && start_cnt == 5'(STARTUP_CYCLES))
        |=> !backup_osc_enable_o) else $error("backup left running");
    a_backup_ticks: assert property (@(posedge clk_i) disable iff (rst_i) // R03 R04
        (on_backup_o && backup_osc_edge_i && gap_cnt == 2'h0) |-> clk_tick_o)
        else $error("backup tick lost");
    a_guard_gap: assert property (@(posedge clk_i) disable iff (rst_i) // R08
        (GUARD_EN && clk_tick_o) |=> !clk_tick_o [*2]) else $error("guard gap");
    a_div_periph: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        periph_tick_o |-> periph_seen == PERIPH_DIV - 4'h1)
        else $error("peripheral divide wrong");
    a_div_cpu: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        cpu_tick_o |-> cpu_seen == CPU_DIV - 4'h1)
        else $error("cpu divide wrong");

    // Reset sequencing checks
    a_pin_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        pin_sync2 |=> core_reset_o [*4]) else $error("pin reset short");
    a_pullup_reset: assert property (@(posedge clk_i) disable iff (rst_i) // R09 R11 R12
        any_reset |=> (io_pullup_o && core_reset_o))
        else $error("reset source ignored");
    a_wd_reinit: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        internal_src |=> watchdog_reinit_o)
        else $error("watchdog not reinitialised");
    a_stab_wait: assert property (@(posedge clk_i) disable iff (rst_i) // R13 R23
        (state == ST_STAB && !(clk_tick_o && stab_cnt == 16'(STAB_LEN - 1)))
        |=> !pc_load_o) else $error("stabilisation cut short");
    a_wired_and: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        (src_sync2 && core_reset_o) |-> (reset_pin_oe_o && !reset_pin_o))
        else $error("pin not pulled");
    a_vector_load: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        $fell(core_reset_o) |-> (pc_load_o && stack_clear_o && nmi_context_o))
        else $error("no vector load");
    a_nmi_set: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        core_reset_o |=> nmi_context_o)
        else $error("nmi context not entered");
    a_nmi_exit: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        (nmi_context_o && return_from_interrupt_i && !core_reset_o) |=> !nmi_context_o)
        else $error("nmi not left");

    // Register bus checks
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !hit) |=> (wb_err_o && !wb_ack_o))
        else $error("unmapped access not refused");

    c_pin_reset: cover property (@(posedge clk_i) pin_sync2 ##[1:200] pc_load_o);
    c_backup: cover property (@(posedge clk_i) $rose(on_backup_o));
    c_wd_reset: cover property (@(posedge clk_i) watchdog_end_i ##[1:200] pc_load_o);
    c_stop_reset: cover property (@(posedge clk_i) stop_mode_i && any_reset); // R12
    c_main_return: cover property (@(posedge clk_i) $fell(on_backup_o)); // R05
endmodule : csr_clock_reset

// >>> pkg/csr_pkg.sv
// Constants and types for the clock safeguard and reset control block
// Functional notes
// R01: Backup oscillator starts one period after missing edge
// R02: Backup clock only with guard option enabled
// R03: Backup clock keeps CPU running, slower
// R04: Backup clock times power-on delay
// R05: Backup stops once main oscillator starts
// R06: Control bit 2 stops main oscillator
// R07: Other control bits have no function
// R08: Guard drops cycles above maximum frequency
// R09: Four reset sources merge into one
// R10: Pin reset stretched, held while pin low
// R11: Run or wait reset halts, pulls up, restarts
// R12: Stop mode reset starts oscillator, pulls up
// R13: Power-up holds reset until stabilisation delay
// R14: Watchdog end-of-count resets, reinitialises watchdog
// R15: Watchdog reset restarts like pin reset
// R16: Low supply holds static reset
// R17: Internal sources drive reset pin low
// R18: Reset clears stack, loads reset vector
// R19: Reset enters non-maskable context
// R20: First return serves pending interrupt
// R21: Divide by 12 peripherals, 13 CPU
// R22: Clearing stop bit or reset restarts oscillator
// R23: Stabilisation delay is parameterised counter
// R24: Reset requests synchronised, released synchronously
package csr_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'hD1;
    localparam logic [7:0] STAT_ADDR = 8'hD2;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam int OSC_OFF_BIT = 2;
    localparam logic [11:0] RESET_VECTOR = 12'hFFE;
    localparam logic [3:0] PERIPH_DIV = 4'hC;
    localparam logic [3:0] CPU_DIV = 4'hD;
    localparam int STAB_CYCLES = 64;
    localparam int STARTUP_CYCLES = 16;
    localparam int PIN_STRETCH = 4;
    localparam int MISS_LIMIT = 3;
    localparam int GUARD_MIN_GAP = 2;
    typedef enum logic [3:0]
    {
        ST_RESET = 4'h1,
        ST_STAB = 4'h2,
        ST_INIT = 4'h4,
        ST_RUN = 4'h8
    } csr_state_type;
endpackage : csr_pkg

// >>> verif/csr_osc_model.sv
// Behavioural oscillators and board reset wiring around the block
`timescale 1ns/1ps
module csr_osc_model #(
    parameter int MAIN_HALF = 2,
    parameter int BACKUP_HALF = 8,
    parameter int START_DLY = 6
) (
    input wire logic clk_i,
    input wire logic main_en_i,
    input wire logic backup_en_i,
    input wire logic fail_i,
    input wire logic board_rst_n_i,
    input wire logic pin_o_i,
    input wire logic pin_oe_i,
    output logic main_edge_o,
    output logic backup_edge_o,
    output logic pin_n_o
);
    int main_cnt = 0;
    int backup_cnt = 0;
    int start_cnt = 0;
    // Wired-AND pin, built-in pull-up when nobody pulls
    assign pin_n_o = board_rst_n_i & ~(pin_oe_i & ~pin_o_i);
    // Oscillators stay silent while off; main restart costs a start-up delay, backup restart none
    always_ff @(posedge clk_i)
    begin
        // Unknown enable before the first reset edge must not poison the count
        start_cnt <= (main_en_i !== 1'b1) ? 0
            : (start_cnt < START_DLY) ? start_cnt + 1 : start_cnt;
        main_cnt <= (main_cnt + 1) % MAIN_HALF;
        backup_cnt <= (backup_cnt + 1) % BACKUP_HALF;
        // A failure silences the main oscillator without a new start-up
        main_edge_o <= main_en_i && !fail_i && start_cnt == START_DLY && main_cnt == 0;
        backup_edge_o <= backup_en_i && backup_cnt == 0;
    end
endmodule : csr_osc_model

// >>> verif/tb_clock_safeguard_reset_control.sv
// Self-checking bench for the clock safeguard and reset block
`timescale 1ns/1ps
module tb_clock_safeguard_reset_control;
    import csr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [7:0] wb_dat_i = 8'h00;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [3:0] req = 4'h0;
    logic rfi = 1'b0;
    logic irq = 1'b0;
    logic sel = 1'b1;
    logic stop_m = 1'b0;
    logic osc_fail = 1'b0;
    logic [7:0] rd;
    logic er;
    int cnt;
    int num_errors = 0;
    int num_checks = 0;
    wire [7:0] wb_dat_o;
    wire [11:0] pc_vec;
    wire wb_ack_o, wb_err_o, main_edge, backup_edge, pin_n, pin_o, pin_oe;
    wire main_en, backup_en, clk_tick, on_backup, periph_tick, cpu_tick, core_rst;
    wire io_pullup, wd_reinit, stack_clear, pc_load, nmi_ctx, serve_irq;
    wire [7:0] obs = {main_en, cpu_tick, periph_tick, clk_tick, on_backup, backup_en,
        pc_load, core_rst};
    always #12.5 clk_i = ~clk_i;
    csr_osc_model PM (.clk_i(clk_i), .main_en_i(main_en), .backup_en_i(backup_en),
        .fail_i(osc_fail), .board_rst_n_i(~req[0]), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .main_edge_o(main_edge), .backup_edge_o(backup_edge), .pin_n_o(pin_n));
    csr_clock_reset #(.STAB_LEN(4), .GUARD_EN(1'b1)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(sel),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .main_osc_edge_i(main_edge), .backup_osc_edge_i(backup_edge),
        .reset_pin_n_i(pin_n), .reset_pin_o(pin_o), .reset_pin_oe_o(pin_oe),
        .power_on_i(req[1]), .watchdog_end_i(req[2]), .low_supply_i(req[3]),
        .stop_mode_i(stop_m), .return_from_interrupt_i(rfi), .irq_pending_i(irq),
        .main_osc_enable_o(main_en), .backup_osc_enable_o(backup_en),
        .clk_tick_o(clk_tick), .on_backup_o(on_backup), .periph_tick_o(periph_tick),
        .cpu_tick_o(cpu_tick), .core_reset_o(core_rst), .io_pullup_o(io_pullup),
        .watchdog_reinit_o(wd_reinit), .stack_clear_o(stack_clear), .pc_load_o(pc_load),
        .pc_vector_o(pc_vec), .nmi_context_o(nmi_ctx), .serve_irq_o(serve_irq));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask : chk
    // Bounded wait on one watched output, sampled clear of the edge
    task automatic wait_bit(input int idx, input logic v, input int lim);
        int n;
        n = 0;
        while (obs[idx] !== v && n < lim)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(16'(obs[idx]), 16'(v));
    endtask : wait_bit
    // Waits for the answer however long it takes; the watchdog ends a hang
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_bit(1, 1'b1, 2000);
        chk(16'(stack_clear), 16'h0001);
        chk(16'(pc_vec), 16'(RESET_VECTOR));
        wait_bit(0, 1'b0, 20);
        chk(16'(nmi_ctx), 16'h0001);
        $display("test power-up done");
        wb(CTRL_ADDR, 1'b0, 8'h00);
        chk(16'(rd), 16'(CTRL_RESET));
        wb(8'h55, 1'b0, 8'h00);
        chk(16'(er), 16'h0001);
        wb(CTRL_ADDR, 1'b1, 8'hFB);
        chk(16'(main_en), 16'h0001);
        sel <= 1'b0;
        wb(CTRL_ADDR, 1'b1, 8'h04);
        sel <= 1'b1;
        chk(16'(main_en), 16'h0001);
        wb(CTRL_ADDR, 1'b0, 8'h00);
        chk(16'(rd), 16'h00FB);
        wb(CTRL_ADDR, 1'b1, 8'h04);
        wait_bit(7, 1'b0, 3);
        wait_bit(2, 1'b1, 50);
        wait_bit(3, 1'b1, 50);
        wait_bit(4, 1'b1, 50);
        wb(CTRL_ADDR, 1'b1, 8'h40);
        wait_bit(3, 1'b0, 300);
        wait_bit(2, 1'b0, 20);
        wb(STAT_ADDR, 1'b0, 8'h00);
        chk(16'(rd), 16'h0009);
        osc_fail <= 1'b1;
        wait_bit(3, 1'b1, 10);
        @(posedge clk_i);
        osc_fail <= 1'b0;
        wait_bit(3, 1'b0, 100);
        $display("test oscillator switch done");
        for (int k = 0; k < 2; k++)
        begin
            wait_bit(5 + k, 1'b1, 400);
            cnt = 0;
            do
            begin
                @(posedge clk_i);
                #1;
                cnt += obs[4];
            end
            while (obs[5 + k] !== 1'b1 && cnt < 40);
            chk(16'(cnt), 16'(12 + k));
        end
        $display("test dividers done");
        // Pin, power-on, watchdog, low supply in turn
        for (int k = 0; k < 4; k++)
        begin
            wb(CTRL_ADDR, 1'b1, 8'h44);
            @(posedge clk_i);
            req[k] <= 1'b1;
            stop_m <= (k == 0);
            wait_bit(0, 1'b1, 8);
            chk(16'(io_pullup), 16'h0001);
            chk(16'(wd_reinit), 16'h0001);
            chk(16'(pin_oe), 16'(k != 0));
            @(posedge clk_i);
            req[k] <= (k == 3);
            stop_m <= 1'b0;
            repeat (20) @(posedge clk_i);
            chk(16'(core_rst), 16'h0001);
            req[3] <= 1'b0;
            wait_bit(1, 1'b1, 2000);
            chk(16'(main_en), 16'h0001);
            wait_bit(0, 1'b0, 20);
            chk(16'(nmi_ctx), 16'h0001);
            @(posedge clk_i);
            rfi <= 1'b1;
            irq <= k[0];
            #1;
            chk(16'(serve_irq), 16'(k[0]));
            @(posedge clk_i);
            rfi <= 1'b0;
            #1;
            chk(16'(nmi_ctx), 16'h0000);
        end
        $display("test reset sources done");
        tally_and_finish();
    end
endmodule : tb_clock_safeguard_reset_control
